// File: pip_pkg.sv
// Package for the port interrupt priority/enable block.
// Assumes a single system clock and AXI4-Lite register access.
package pip_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [11:0] IDX_G0_REQ   = 12'hFC0;
  localparam logic [11:0] IDX_G0_ENH   = 12'hFC1;
  localparam logic [11:0] IDX_G0_ENL   = 12'hFC2;
  localparam logic [11:0] IDX_G1_REQ   = 12'hFC3;
  localparam logic [11:0] IDX_G1_ENH   = 12'hFC4;
  localparam logic [11:0] IDX_G1_ENL   = 12'hFC5;
  localparam logic [11:0] IDX_G2_REQ   = 12'hFC6;
  localparam logic [11:0] IDX_G2_ENH   = 12'hFC7;
  localparam logic [11:0] IDX_G2_ENL   = 12'hFC8;
  localparam logic [11:0] IDX_STATUS   = 12'hFC9;
  localparam logic [11:0] IDX_MASK     = 12'hFCA;
  localparam logic [11:0] IDX_PORT_SEL = 12'hFCE;
  localparam logic [11:0] IDX_CTL      = 12'hFCF;

  // ==========================================================================
  // Field positions and reset values
  localparam int          CTL_GIE_BIT  = 7;
  localparam int          SEL_CMP_BIT  = 6;
  localparam int          G2_PINS      = 4;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [2:0]  STAT_RESET   = 3'h0;

  // ==========================================================================
  // Source numbering and priority codes
  localparam int          NUM_SRC      = 20;
  localparam logic [4:0]  G1_BASE      = 5'h08;
  localparam logic [4:0]  G2_BASE      = 5'h10;
  localparam logic [1:0]  LVL_OFF      = 2'h0;

  // ==========================================================================
  // AXI response codes
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic       valid;
    logic [1:0] level;
    logic [4:0] vector;
  } pip_core_req_t;

endpackage

// File: pip_prio_pick.sv
// Priority picker: chooses the pending source with the highest level.
// Assumes levels and pending bits come from the same clock domain.
`timescale 1ns/100ps
module pip_prio_pick #(
  parameter int N = 20
) (
  input  wire logic [2*N-1:0] levels,
  input  wire logic [N-1:0]   pend,
  output logic                valid,
  output logic [4:0]          idx,
  output logic [1:0]          level
);

  initial begin
    if (N < 1 || N > 32) begin
      $error("pip_prio_pick: N out of range");
    end
  end

  // ==========================================================================
  // Highest level wins, lowest index breaks ties
  always_comb begin
    valid = 1'b0;
    idx   = 5'h00;
    level = 2'h0;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && levels[2*i +: 2] > level) begin
        valid = 1'b1;
        idx   = 5'(i);
        level = levels[2*i +: 2];
      end
    end
  end

endmodule // pip_prio_pick

// File: pip_ctrl.sv
// Port interrupt priority/enable controller with AXI4-Lite registers.
// Assumes pins are asynchronous, first group events are same-clock pulses.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pip_ctrl
  import pip_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [7:0]            first_group_evt,
  input  wire logic [7:0]            port_a_pin,
  input  wire logic [5:0]            port_d_pin,
  input  wire logic                  comparator_out,
  input  wire logic [3:0]            port_c_pin,
  output pip_pkg::pip_core_req_t     core_req,
  input  wire logic                  core_ack,
  input  wire logic [4:0]            core_ack_vector,
  output logic                       irq
);

  initial begin
    if (ADDR_W < 14) begin
      $error("pip_ctrl: ADDR_W must be at least 14");
    end
  end

  // ==========================================================================
  // Functions
  function automatic logic [7:0] upd8(input logic [7:0] cur, input logic wen,
                                      input logic [7:0] wd, input logic [7:0] clr,
                                      input logic [7:0] set);
    logic [7:0] v;
    v = cur & ~clr;
    if (wen) begin
      v = wd;
    end
    return v | set;
  endfunction

  function automatic logic [1:0] lvl(input logic h, input logic l);
    return {h, l};
  endfunction

  // ==========================================================================
  // Declarations
  logic [7:0]           g0_req_ff, g0_enh_ff, g0_enl_ff;
  logic [7:0]           g1_req_ff, g1_enh_ff, g1_enl_ff;
  logic [3:0]           g2_req_ff;
  logic [7:0]           nxt_g2_req;
  logic [7:0]           g2_enh_ff, g2_enl_ff;
  logic [7:0]           port_sel_ff, ctl_ff;
  logic [2:0]           status_ff, mask_ff;
  logic [18:0]          pin_s1_ff, pin_s2_ff, pin_prev_ff;
  logic [18:0]          pin_rise;
  logic [7:0]           g1_set;
  logic [3:0]           g2_set;
  logic                 aw_full_ff, w_full_ff;
  logic [11:0]          aw_idx_ff;
  logic [7:0]           w_data_ff;
  logic                 w_lane0_ff;
  logic                 do_write, rd_take;
  logic [11:0]          ar_idx;
  logic                 bvalid_ff, rvalid_ff;
  logic [1:0]           bresp_ff, rresp_ff;
  logic [31:0]          rdata_ff;
  logic [7:0]           rd_val;
  logic                 rd_hit, wr_hit;
  logic [2*NUM_SRC-1:0] all_lvl;
  logic [NUM_SRC-1:0]   all_pend;
  logic                 pick_valid;
  logic [4:0]           pick_idx;
  logic [1:0]           pick_level;
  pip_core_req_t        core_req_ff;
  logic [NUM_SRC-1:0]   ack_clr;
  logic                 gie;

  // ==========================================================================
  // Pin synchronisers and rising edge detect
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_s1_ff   <= '0;
      pin_s2_ff   <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_s1_ff   <= {comparator_out, port_d_pin, port_a_pin, port_c_pin};
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  assign pin_rise = pin_s2_ff & ~pin_prev_ff;
  assign g2_set   = pin_rise[3:0];

  always_comb begin
    g1_set[7] = pin_rise[11];
    g1_set[6] = port_sel_ff[SEL_CMP_BIT] ? pin_rise[18] : pin_rise[10];
    for (int i = 0; i < 6; i++) begin
      g1_set[i] = port_sel_ff[i] ? pin_rise[12+i] : pin_rise[4+i];
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  assign s_axi_awready = ~aw_full_ff;
  assign s_axi_wready  = ~w_full_ff;
  assign do_write      = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_full_ff <= 1'b0;
      aw_idx_ff  <= 12'h000;
    end else if (s_axi_awvalid && !aw_full_ff) begin
      aw_full_ff <= 1'b1;
      aw_idx_ff  <= s_axi_awaddr[13:2];
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      w_full_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (s_axi_wvalid && !w_full_ff) begin
      w_full_ff  <= 1'b1;
      w_data_ff  <= s_axi_wdata[7:0];
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_full_ff  <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_idx_ff)
      IDX_G0_REQ, IDX_G0_ENH, IDX_G0_ENL, IDX_G1_REQ, IDX_G1_ENH, IDX_G1_ENL,
      IDX_G2_REQ, IDX_G2_ENH, IDX_G2_ENL, IDX_STATUS, IDX_MASK, IDX_PORT_SEL,
      IDX_CTL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  function automatic logic wr_to(input logic [11:0] idx, input logic [11:0] a,
                                 input logic dw, input logic lane);
    return dw && lane && (a == idx);
  endfunction

  // ==========================================================================
  // Enable, select and control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      g0_enh_ff   <= REG_RESET;
      g0_enl_ff   <= REG_RESET;
      g1_enh_ff   <= REG_RESET;
      g1_enl_ff   <= REG_RESET;
      g2_enh_ff   <= REG_RESET;
      g2_enl_ff   <= REG_RESET;
      port_sel_ff <= REG_RESET;
      ctl_ff      <= REG_RESET;
      mask_ff     <= STAT_RESET;
    end else if (do_write && w_lane0_ff) begin
      if (aw_idx_ff == IDX_G0_ENH)   g0_enh_ff   <= w_data_ff;
      if (aw_idx_ff == IDX_G0_ENL)   g0_enl_ff   <= w_data_ff;
      if (aw_idx_ff == IDX_G1_ENH)   g1_enh_ff   <= w_data_ff;
      if (aw_idx_ff == IDX_G1_ENL)   g1_enl_ff   <= w_data_ff;
      if (aw_idx_ff == IDX_G2_ENH)   g2_enh_ff   <= w_data_ff;
      if (aw_idx_ff == IDX_G2_ENL)   g2_enl_ff   <= w_data_ff;
      if (aw_idx_ff == IDX_PORT_SEL) port_sel_ff <= w_data_ff;
      if (aw_idx_ff == IDX_CTL)      ctl_ff      <= w_data_ff;
      if (aw_idx_ff == IDX_MASK)     mask_ff     <= w_data_ff[2:0];
    end
  end

  assign gie = ctl_ff[CTL_GIE_BIT];

  // ==========================================================================
  // Request registers: hardware set wins over write and acknowledge
  always_comb begin
    ack_clr = '0;
    if (core_ack && core_ack_vector < 5'(NUM_SRC)) begin
      ack_clr[core_ack_vector] = 1'b1;
    end
  end

  assign nxt_g2_req = upd8({4'h0, g2_req_ff}, wr_to(IDX_G2_REQ, aw_idx_ff, do_write, w_lane0_ff),
                           w_data_ff, {4'h0, ack_clr[19:16]}, {4'h0, g2_set});

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      g0_req_ff <= REG_RESET;
      g1_req_ff <= REG_RESET;
      g2_req_ff <= 4'h0;
    end else begin
      g0_req_ff <= upd8(g0_req_ff, wr_to(IDX_G0_REQ, aw_idx_ff, do_write, w_lane0_ff),
                        w_data_ff, ack_clr[7:0], first_group_evt);
      g1_req_ff <= upd8(g1_req_ff, wr_to(IDX_G1_REQ, aw_idx_ff, do_write, w_lane0_ff),
                        w_data_ff, ack_clr[15:8], g1_set);
      g2_req_ff <= nxt_g2_req[G2_PINS-1:0];
    end
  end

  // ==========================================================================
  // Status, mask and interrupt output
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_ff <= STAT_RESET;
    end else begin
      status_ff <= ((rd_take && ar_idx == IDX_STATUS) ? 3'h0 : status_ff)
                   | {|g2_set, |g1_set, |first_group_evt};
    end
  end

  assign irq = |(status_ff & mask_ff);

  // ==========================================================================
  // Priority selection and core request
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      all_lvl[2*i +: 2]      = lvl(g0_enh_ff[i], g0_enl_ff[i]);
      all_lvl[2*(i+8) +: 2]  = lvl(g1_enh_ff[i], g1_enl_ff[i]);
    end
    for (int i = 0; i < G2_PINS; i++) begin
      all_lvl[2*(i+16) +: 2] = lvl(g2_enh_ff[i], g2_enl_ff[i]);
    end
  end

  assign all_pend = {g2_req_ff, g1_req_ff, g0_req_ff};

  pip_prio_pick #(
    .N      (NUM_SRC)
  ) u_pick (
    .levels (all_lvl),
    .pend   (all_pend),
    .valid  (pick_valid),
    .idx    (pick_idx),
    .level  (pick_level)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_req_ff <= '0;
    end else begin
      core_req_ff.valid  <= gie & pick_valid;
      core_req_ff.level  <= pick_level;
      core_req_ff.vector <= pick_idx;
    end
  end

  assign core_req = core_req_ff;

  // ==========================================================================
  // AXI4-Lite read path
  assign ar_idx        = s_axi_araddr[13:2];
  assign s_axi_arready = ~rvalid_ff;
  assign rd_take       = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    rd_hit = 1'b1;
    unique case (ar_idx)
      IDX_G0_REQ:   rd_val = g0_req_ff;
      IDX_G0_ENH:   rd_val = g0_enh_ff;
      IDX_G0_ENL:   rd_val = g0_enl_ff;
      IDX_G1_REQ:   rd_val = g1_req_ff;
      IDX_G1_ENH:   rd_val = g1_enh_ff;
      IDX_G1_ENL:   rd_val = g1_enl_ff;
      IDX_G2_REQ:   rd_val = {4'h0, g2_req_ff};
      IDX_G2_ENH:   rd_val = g2_enh_ff;
      IDX_G2_ENL:   rd_val = g2_enl_ff;
      IDX_STATUS:   rd_val = {5'h00, status_ff};
      IDX_MASK:     rd_val = {5'h00, mask_ff};
      IDX_PORT_SEL: rd_val = port_sel_ff;
      IDX_CTL:      rd_val = ctl_ff;
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {24'h000000, rd_val};
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  logic [1:0] max_pend_lvl;

  always_comb begin
    max_pend_lvl = LVL_OFF;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (all_pend[i] && all_lvl[2*i +: 2] > max_pend_lvl) begin
        max_pend_lvl = all_lvl[2*i +: 2];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_pc_rise;
    |g2_set;
  endsequence

  sequence s_pend_enabled_gie;
    gie && pick_valid;
  endsequence

  sequence s_both_taken;
    aw_full_ff && w_full_ff && !bvalid_ff;
  endsequence

  property p_pc_pending_set;
    s_pc_rise |=> ((g2_req_ff & $past(g2_set)) == $past(g2_set));
  endproperty
  a_pc_pending_set: assert property (p_pc_pending_set)
    else $error("Port C request not latched");

  property p_forward_when_enabled;
    s_pend_enabled_gie |=> core_req.valid && core_req.level != LVL_OFF;
  endproperty
  a_forward_when_enabled: assert property (p_forward_when_enabled)
    else $error("Pending enabled request not forwarded");

  property p_no_core_req_when_disabled;
    !gie |=> !core_req.valid;
  endproperty
  a_no_core_req_when_disabled: assert property (p_no_core_req_when_disabled)
    else $error("Core request while globally disabled");

  property p_pc_reserved_read_zero;
    (rd_take && ar_idx == IDX_G2_REQ) |=> s_axi_rvalid && s_axi_rdata[7:4] == 4'h0;
  endproperty
  a_pc_reserved_read_zero: assert property (p_pc_reserved_read_zero)
    else $error("Reserved request bits read non-zero");

  property p_disabled_never_picked;
    pick_valid |-> pick_level == all_lvl[2*pick_idx +: 2] && pick_level != LVL_OFF;
  endproperty
  a_disabled_never_picked: assert property (p_disabled_never_picked)
    else $error("Disabled or mis-coded source picked");

  property p_pin7_low_enable;
    (pick_valid && pick_idx == 5'd15) |-> (g1_enl_ff[7] || g1_enh_ff[7]);
  endproperty
  a_pin7_low_enable: assert property (p_pin7_low_enable)
    else $error("Port A pin 7 picked while disabled");

  property p_shared_source;
    (pin_rise[18] && port_sel_ff[SEL_CMP_BIT]) |-> g1_set[6] ##1 g1_req_ff[6];
  endproperty
  a_shared_source: assert property (p_shared_source)
    else $error("Comparator request not latched");

  property p_port_select;
    (pin_rise[12] && port_sel_ff[0]) || (pin_rise[4] && !port_sel_ff[0]) |=> g1_req_ff[0];
  endproperty
  a_port_select: assert property (p_port_select)
    else $error("Selected port request not latched");

  property p_highest_first;
    pick_valid |-> pick_level == max_pend_lvl;
  endproperty
  a_highest_first: assert property (p_highest_first)
    else $error("Lower priority request presented first");

  property p_write_answer;
    s_both_taken |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("Write response missing");

endmodule // pip_ctrl

// File: pip_core_model.sv
// Core model: takes vectored requests from the controller and acknowledges them.
// Assumes the controller's clock and synchronous reset; ack_en low stops it acknowledging.
`timescale 1ns/100ps
module pip_core_model
  import pip_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire pip_pkg::pip_core_req_t core_req,
  input  wire logic                   ack_en,
  output logic                        core_ack,
  output logic [4:0]                  core_ack_vector,
  output logic [7:0]                  ack_count,
  output logic [4:0]                  last_vec,
  output logic [1:0]                  last_lvl
);
  logic [1:0] hold_ff;

  // ==========================================================================
  // Acknowledge the presented vector, then skip the stale request cycles
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_ack        <= 1'b0;
      core_ack_vector <= 5'h1F;
      hold_ff         <= 2'h0;
      ack_count       <= 8'h00;
      last_vec        <= 5'h00;
      last_lvl        <= 2'h0;
    end else begin
      core_ack        <= 1'b0;
      core_ack_vector <= ~core_ack_vector;
      if (hold_ff != 2'h0) begin
        hold_ff <= hold_ff - 2'h1;
      end else if (ack_en && core_req.valid) begin
        core_ack        <= 1'b1;
        core_ack_vector <= core_req.vector;
        last_vec        <= core_req.vector;
        last_lvl        <= core_req.level;
        ack_count       <= ack_count + 8'h01;
        hold_ff         <= 2'h2;
      end
    end
  end
endmodule // pip_core_model

// File: tb_port_interrupt_priority_enable.sv
// Testbench for the port interrupt priority/enable controller.
// Assumes pip_pkg, the design files and the core model are compiled first.
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_port_interrupt_priority_enable;
  import pip_pkg::*;
  logic          ref_clk = 1'b0;
  logic          reset = 1'b1;
  logic [13:0]   awaddr = 14'h0000, araddr = 14'h0000;
  logic [31:0]   wdata = 32'h00000000, rdata;
  logic [3:0]    wstrb = 4'hF;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid, irq, core_ack;
  logic [1:0]    bresp, rresp, last_lvl;
  logic [7:0]    first_group_evt = 8'h00, port_a_pin = 8'h00, ack_count, nack = 8'h00;
  logic [5:0]    port_d_pin = 6'h00;
  logic          comparator_out = 1'b0, ack_en = 1'b1;
  logic [3:0]    port_c_pin = 4'h0;
  logic [4:0]    core_ack_vector, last_vec;
  pip_core_req_t core_req;
  int            fail_count = 0, comparisons = 0, cycles = 0;

  pip_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .first_group_evt(first_group_evt),
    .port_a_pin(port_a_pin), .port_d_pin(port_d_pin), .comparator_out(comparator_out),
    .port_c_pin(port_c_pin), .core_req(core_req), .core_ack(core_ack),
    .core_ack_vector(core_ack_vector), .irq(irq));
  pip_core_model i_core (.ref_clk(ref_clk), .reset(reset), .core_req(core_req), .ack_en(ack_en),
    .core_ack(core_ack), .core_ack_vector(core_ack_vector), .ack_count(ack_count),
    .last_vec(last_vec), .last_lvl(last_lvl));

  // ==========================================================================
  // Clock, timeout and verdict
  always #5 ref_clk = ~ref_clk;

  task automatic conclude;
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================================================
  // Register bus tasks
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp, input logic [1:0] er);
    @(posedge ref_clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(rdata, {24'h000000, exp})
    `CHK(rresp, er)
  endtask

  // ==========================================================================
  // Source stimulus: kind 0 event, 1 Port A, 2 Port D, 3 comparator, 4 Port C
  task automatic rise(input int kind, input int b);
    @(posedge ref_clk);
    case (kind)
      0:       first_group_evt[b] <= 1'b1;
      1:       port_a_pin[b] <= 1'b1;
      2:       port_d_pin[b] <= 1'b1;
      3:       comparator_out <= 1'b1;
      default: port_c_pin[b] <= 1'b1;
    endcase
    @(posedge ref_clk);
    first_group_evt <= 8'h00;
    repeat (3) @(posedge ref_clk);
    port_a_pin     <= 8'h00;
    port_d_pin     <= 6'h00;
    comparator_out <= 1'b0;
    port_c_pin     <= 4'h0;
  endtask

  task automatic wait_ack;
    int i;
    for (i = 0; i < 40 && ack_count !== nack; i++) @(posedge ref_clk);
    `CHK(ack_count, nack)
  endtask

  // Set enables, raise one source, check the core's answer and what stays pending
  task automatic src_case(input logic [11:0] hi_i, input logic [11:0] lo_i, input logic [11:0] req_i,
                          input logic [7:0] hi_d, input logic [7:0] lo_d, input int kind, input int b,
                          input logic [4:0] vec, input logic [1:0] lvl, input logic [7:0] left);
    wr(hi_i, hi_d, RESP_OKAY);
    wr(lo_i, lo_d, RESP_OKAY);
    rise(kind, b);
    if (lvl != LVL_OFF) nack = nack + 8'h01;
    wait_ack();
    if (lvl != LVL_OFF) begin
      `CHK(last_vec, vec)
      `CHK(last_lvl, lvl)
    end
    repeat (3) @(posedge ref_clk);
    rd_chk(req_i, left, RESP_OKAY);
    wr(req_i, 8'h00, RESP_OKAY);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [1:0] c;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(IDX_G1_ENL, REG_RESET, RESP_OKAY);
    rd_chk(IDX_G2_REQ, REG_RESET, RESP_OKAY);
    rd_chk(12'hFCB, 8'h00, RESP_SLVERR);
    wr(12'hFCB, 8'h55, RESP_SLVERR);
    wr(IDX_G2_ENH, 8'h04, RESP_OKAY);
    wr(IDX_G2_ENL, 8'h04, RESP_OKAY);
    rise(4, 2);
    repeat (8) @(posedge ref_clk);
    `CHK(core_req.valid, 1'b0)
    `CHK(ack_count, 8'h00)
    rd_chk(IDX_G2_REQ, 8'h04, RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(IDX_MASK, 8'h04, RESP_OKAY);
    `CHK(irq, 1'b1)
    rd_chk(IDX_STATUS, 8'h04, RESP_OKAY);
    `CHK(irq, 1'b0)
    wr(IDX_CTL, 8'h80, RESP_OKAY);
    nack = 8'h01;
    wait_ack();
    `CHK(last_vec, G2_BASE + 5'h02)
    `CHK(last_lvl, 2'h3)
    repeat (3) @(posedge ref_clk);
    rd_chk(IDX_G2_REQ, 8'h00, RESP_OKAY);
    wr(IDX_G2_REQ, 8'h0A, RESP_OKAY);
    rd_chk(IDX_G2_REQ, 8'h0A, RESP_OKAY);
    wr(IDX_G2_REQ, 8'h00, RESP_OKAY);
    for (int ci = 0; ci < 4; ci++) begin
      c = ci[1:0];
      src_case(IDX_G0_ENH, IDX_G0_ENL, IDX_G0_REQ, {4'h0, c[1], 3'h0}, {4'h0, c[0], 3'h0}, 0, 3,
               5'h03, c, (c == LVL_OFF) ? 8'h08 : 8'h00);
      src_case(IDX_G2_ENH, IDX_G2_ENL, IDX_G2_REQ, {7'h00, c[1]}, {7'h00, c[0]}, 4, 0,
               G2_BASE, c, (c == LVL_OFF) ? 8'h01 : 8'h00);
    end
    src_case(IDX_G1_ENH, IDX_G1_ENL, IDX_G1_REQ, 8'h00, 8'h80, 1, 7, G1_BASE + 5'h07, 2'h1, 8'h00);
    wr(IDX_PORT_SEL, 8'h40, RESP_OKAY);
    src_case(IDX_G1_ENH, IDX_G1_ENL, IDX_G1_REQ, 8'h00, 8'h40, 3, 0, G1_BASE + 5'h06, 2'h1, 8'h00);
    wr(IDX_PORT_SEL, 8'h04, RESP_OKAY);
    src_case(IDX_G1_ENH, IDX_G1_ENL, IDX_G1_REQ, 8'h00, 8'h04, 2, 2, G1_BASE + 5'h02, 2'h1, 8'h00);
    src_case(IDX_G1_ENH, IDX_G1_ENL, IDX_G1_REQ, 8'h00, 8'h04, 1, 2, G1_BASE + 5'h02, LVL_OFF, 8'h00);
    @(posedge ref_clk) ack_en <= 1'b0;
    wr(IDX_G2_ENH, 8'h08, RESP_OKAY);
    wr(IDX_G2_ENL, 8'h0A, RESP_OKAY);
    rise(4, 1);
    rise(4, 3);
    repeat (4) @(posedge ref_clk);
    ack_en <= 1'b1;
    nack = nack + 8'h01;
    wait_ack();
    `CHK(last_vec, G2_BASE + 5'h03)
    nack = nack + 8'h01;
    wait_ack();
    `CHK(last_vec, G2_BASE + 5'h01)
    `CHK(last_lvl, 2'h1)
    wstrb <= 4'hE;
    wr(IDX_CTL, 8'h00, RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(IDX_CTL, 8'h80, RESP_OKAY);
    conclude();
  end
endmodule // tb_port_interrupt_priority_enable
